// >>> src/zsr_pkg.sv
// Shared constants and carriers of the pipelined synchronous SRAM cycle logic.
// Assumes a single 40 MHz clock that samples every pin on its rising edge.
package zsr_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W     = 18;
  localparam int LANES      = 4;
  localparam int LANE_W     = 8;
  localparam int DATA_W     = LANES * LANE_W + LANES;
  localparam int EXTRA_LSB  = LANES * LANE_W;
  localparam int FIFO_DEPTH = 32;

  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam int   DATA_LAT_CYC = 2;
  localparam logic OE_N_RST     = 1'b1;
  localparam logic [1:0] CNT_RST   = 2'h0;
  localparam logic [1:0] CNT_STEP  = 2'h1;
  localparam logic [3:0] LANES_OFF = 4'h0;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  be;
  } zsr_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  be;
    logic [DATA_W-1:0] data;
  } zsr_wr_t;

  localparam int WR_W = $bits(zsr_wr_t);

  typedef struct packed {
    logic              lin_meta;
    logic              lin_n;
    zsr_op_t           s1;
    zsr_op_t           s2;
    zsr_op_t           s3;
    logic [1:0]        burst_base;
    logic [1:0]        burst_cnt;
    logic [DATA_W-1:0] dq_out;
    logic              oe_n;
    logic              busy;
  } zsr_state_t;

endpackage : zsr_pkg

// >>> src/zsr_sram.sv
// Cycle logic of a pipelined synchronous SRAM: command decode, burst counter,
// two-cycle data pipeline, write buffer and the storage array.
// Assumes the memory controller drives all pins but reset_n and linear_order_n synchronously to clock.
//
// Contract
// [RULE1] Selected load with gating off starts read or write; data two cycles later.
// [RULE2] Advance after load or burst steps counter; after deselect or idle, no-op.
// [RULE3] Read/write input is ignored on burst-advance cycles.
// [RULE4] Burst direction is fixed by the value sampled at the load.
// [RULE5] Load cycle with any chip enable inactive starts a deselect.
// [RULE6] Data bus goes high impedance two cycles after a deselect.
// [RULE7] Selected only when select_a_n low, select_c_n low, select_b high.
// [RULE8] Gated edge is ignored: no new operation, no pipeline step.
// [RULE9] On a gated edge every register and the bus drive hold; the linear_order_n synchroniser and write_busy still update.
// [RULE10] Data outputs stay high impedance after power-up until a read.
// [RULE11] Lane 1 writes bits 7:0 plus extra bit 1; lane 2 bits 15:8.
// [RULE12] Lanes 3 and 4 write bits 23:16 and 31:24 with their extras.
// [RULE13] Any lane mix may be written; all high writes nothing; reads ignore lanes.
// [RULE14] Burst steps interleaved when linear_order_n high, linear when low.
// [RULE15] After the fourth address the counter wraps and keeps counting.
// [RULE16] Controller drives write data only in the write data cycle.
`timescale 1ns/10ps

// ------------------------------------------------------------------------
// Write buffer
// ------------------------------------------------------------------------
module zsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [WIDTH-1:0]       in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [WIDTH-1:0]            out_data,
  output logic [DEPTH*WIDTH-1:0]      snoop_data,
  output logic [$clog2(DEPTH)-1:0]    snoop_head,
  output logic [$clog2(DEPTH):0]      snoop_count
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
  } zsr_fifo_state_t;

  zsr_fifo_state_t  st_q;
  zsr_fifo_state_t  st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Full compare needs the extra count bit; a PW-bit cast of DEPTH would be zero
  assign in_ready  = (st_q.count != (PW+1)'(DEPTH));
  assign out_valid = (st_q.count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_q.rd_ptr];
  assign snoop_head  = st_q.rd_ptr;
  assign snoop_count = st_q.count;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      snoop_data[i*WIDTH +: WIDTH] = mem[i];
    end
  end

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr_ptr = st_q.wr_ptr + PW'(1);
    end
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + PW'(1);
    end
    st_d.count = st_q.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Storage has no reset; only the pointers define what is valid
  always_ff @(posedge clock) begin
    if (push) begin
      mem[st_q.wr_ptr] <= in_data;
    end
  end

  a_fifo_no_overrun : assert property (@(posedge clock) disable iff (!rst_n)
    (st_q.count == (PW+1)'(DEPTH)) |-> !push)
    else $error("write buffer overrun");

endmodule : zsr_fifo

// ------------------------------------------------------------------------
// Top: the device behind its pins
// ------------------------------------------------------------------------
module zsr_sram (
  input  wire logic                           clock,
  input  wire logic                           reset_n,
  input  wire logic [zsr_pkg::ADDR_W-1:0]     addr,
  input  wire logic                           read_not_write,
  input  wire logic                           advance_or_load,
  input  wire logic                           select_a_n,
  input  wire logic                           select_b,
  input  wire logic                           select_c_n,
  input  wire logic                           clock_gate_n,
  input  wire logic [zsr_pkg::LANES-1:0]      byte_lane_write_n,
  input  wire logic                           linear_order_n,
  input  wire logic [zsr_pkg::DATA_W-1:0]     dq_in,
  output logic      [zsr_pkg::DATA_W-1:0]     dq_out,
  output logic                                dq_oe_n,
  output logic                                write_busy
);
  localparam int DEPTH = zsr_pkg::FIFO_DEPTH;
  localparam int PW    = $clog2(DEPTH);

  logic                  rst_meta_q;
  logic                  rst_n_q;
  zsr_pkg::zsr_state_t   st_q;
  zsr_pkg::zsr_state_t   st_d;
  logic [zsr_pkg::DATA_W-1:0] mem [2**zsr_pkg::ADDR_W];

  logic                  active;
  logic                  selected;
  logic                  load;
  logic                  advance;
  logic [1:0]            cnt_next;
  logic [1:0]            low_next;
  zsr_pkg::zsr_wr_t      push_word;
  logic                  push_valid;
  logic                  push_ready;
  zsr_pkg::zsr_wr_t      drain_word;
  logic                  drain_valid;
  logic                  drain_ready;
  logic [DEPTH*zsr_pkg::WR_W-1:0] snoop_data;
  logic [PW-1:0]         snoop_head;
  logic [PW:0]           snoop_count;
  logic [zsr_pkg::DATA_W-1:0] rd_data;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  assign active   = !clock_gate_n;                              // see [RULE8]
  assign selected = !select_a_n && !select_c_n && select_b;     // see [RULE7]
  assign load     = active && !advance_or_load && selected;     // see [RULE1]
  assign advance  = active && advance_or_load && st_q.s1.valid; // see [RULE2]
  assign cnt_next = st_q.burst_cnt + zsr_pkg::CNT_STEP;         // see [RULE15]
  // Strap is slow but still asynchronous to clock, hence the synchroniser
  assign low_next = st_q.lin_n ? (st_q.burst_base ^ cnt_next)   // see [RULE14]
                               : (st_q.burst_base + cnt_next);

  // Write data is taken in the data cycle, one edge after the read slot
  assign push_valid      = active && st_q.s3.valid && st_q.s3.write; // see [RULE16]
  assign push_word.addr  = st_q.s3.addr;
  assign push_word.be    = st_q.s3.be;
  assign push_word.data  = dq_in;
  // One array port: a read data cycle or a gated edge stalls the drain
  assign drain_ready = active && !(st_q.s2.valid && !st_q.s2.write);

  // ----------------------------------------------------------------------
  // Read path with forwarding from buffered writes
  // ----------------------------------------------------------------------
  always_comb begin
    zsr_pkg::zsr_wr_t ent;
    logic [PW-1:0]    idx;
    ent     = '0;
    idx     = '0;
    rd_data = mem[st_q.s2.addr];
    for (int i = 0; i < DEPTH; i++) begin
      idx = snoop_head + PW'(i);
      ent = snoop_data[idx*zsr_pkg::WR_W +: zsr_pkg::WR_W];
      if ((i < int'(snoop_count)) && (ent.addr == st_q.s2.addr)) begin
        for (int l = 0; l < zsr_pkg::LANES; l++) begin
          if (ent.be[l]) begin
            rd_data[l*zsr_pkg::LANE_W +: zsr_pkg::LANE_W] = ent.data[l*zsr_pkg::LANE_W +: zsr_pkg::LANE_W];
            rd_data[zsr_pkg::EXTRA_LSB + l] = ent.data[zsr_pkg::EXTRA_LSB + l];
          end
        end
      end
    end
    // Write landing on this very edge must be seen by a read right behind it
    if (push_valid && (push_word.addr == st_q.s2.addr)) begin
      for (int l = 0; l < zsr_pkg::LANES; l++) begin
        if (push_word.be[l]) begin
          rd_data[l*zsr_pkg::LANE_W +: zsr_pkg::LANE_W] = dq_in[l*zsr_pkg::LANE_W +: zsr_pkg::LANE_W];
          rd_data[zsr_pkg::EXTRA_LSB + l] = dq_in[zsr_pkg::EXTRA_LSB + l];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    st_d.lin_meta = linear_order_n;
    st_d.lin_n    = st_q.lin_meta;
    st_d.busy     = !push_ready;
    if (active) begin                                           // see [RULE9]
      if (load) begin
        st_d.s1.valid   = 1'b1;
        st_d.s1.write   = !read_not_write;                      // see [RULE4]
        st_d.s1.addr    = addr;
        st_d.s1.be      = read_not_write ? zsr_pkg::LANES_OFF : ~byte_lane_write_n; // see [RULE13]
        st_d.burst_base = addr[1:0];
        st_d.burst_cnt  = zsr_pkg::CNT_RST;
      end else if (advance) begin
        // Direction held from the load; read_not_write not looked at
        st_d.s1.addr[1:0] = low_next;                           // see [RULE3]
        st_d.s1.be        = st_q.s1.write ? ~byte_lane_write_n : zsr_pkg::LANES_OFF;
        st_d.burst_cnt    = cnt_next;
      end else begin
        st_d.s1.valid = 1'b0;                                   // see [RULE5]
        st_d.s1.be    = zsr_pkg::LANES_OFF;
      end
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // Bus drive follows the op issued two edges back
      st_d.oe_n = !(st_q.s2.valid && !st_q.s2.write);            // see [RULE6]
      if (st_q.s2.valid && !st_q.s2.write) begin
        st_d.dq_out = rd_data;                                  // see [RULE1]
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q      <= '0;
      st_q.oe_n <= zsr_pkg::OE_N_RST;                          // see [RULE10]
    end else begin
      st_q <= st_d;
    end
  end

  assign dq_out     = st_q.dq_out;
  assign dq_oe_n    = st_q.oe_n;
  assign write_busy = st_q.busy;

  // ----------------------------------------------------------------------
  // Write buffer and array
  // ----------------------------------------------------------------------
  zsr_fifo #(
    .WIDTH (zsr_pkg::WR_W),
    .DEPTH (DEPTH)
  ) zsr_fifo_i (
    .clock       (clock),
    .rst_n       (rst_n_q),
    .in_valid    (push_valid),
    .in_ready    (push_ready),
    .in_data     (push_word),
    .out_valid   (drain_valid),
    .out_ready   (drain_ready),
    .out_data    (drain_word),
    .snoop_data  (snoop_data),
    .snoop_head  (snoop_head),
    .snoop_count (snoop_count)
  );

  always_ff @(posedge clock) begin
    if (drain_valid && drain_ready) begin
      for (int l = 0; l < zsr_pkg::LANES; l++) begin
        if (drain_word.be[l]) begin                             // see [RULE11] see [RULE12]
          mem[drain_word.addr][l*zsr_pkg::LANE_W +: zsr_pkg::LANE_W] <= drain_word.data[l*zsr_pkg::LANE_W +: zsr_pkg::LANE_W];
          mem[drain_word.addr][zsr_pkg::EXTRA_LSB + l] <= drain_word.data[zsr_pkg::EXTRA_LSB + l];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_q);

  a_load_read_lat : assert property ( // see [RULE1]
    (load && read_not_write) ##1 active ##1 active |=> !dq_oe_n)
    else $error("read data not driven two cycles after load");

  a_burst_step : assert property ( // see [RULE2]
    advance |=> (st_q.burst_cnt == $past(st_q.burst_cnt) + 2'h1) && st_q.s1.valid)
    else $error("burst counter did not step");

  a_idle_cycle_idle : assert property ( // see [RULE2]
    (active && advance_or_load && !st_q.s1.valid) |=> !st_q.s1.valid)
    else $error("advance after idle started an operation");

  a_burst_dir : assert property ( // see [RULE4]
    advance |=> st_q.s1.write == $past(st_q.s1.write))
    else $error("burst direction changed");

  a_deselect_stop : assert property ( // see [RULE5]
    (active && !advance_or_load && !selected) |=> !st_q.s1.valid)
    else $error("deselect did not stop");

  a_deselect_hiz : assert property ( // see [RULE6]
    (active && !advance_or_load && !selected) ##1 active ##1 active |=> dq_oe_n)
    else $error("bus driven after deselect");

  a_suspend_pipe : assert property ( // see [RULE8]
    !active |=> (st_q.s1 == $past(st_q.s1)) && (st_q.s3 == $past(st_q.s3)))
    else $error("pipeline moved on gated edge");

  a_suspend_bus : assert property ( // see [RULE9]
    !active |=> $stable(dq_out) && $stable(dq_oe_n))
    else $error("bus changed on gated edge");

  a_power_up_hiz : assert property ( // see [RULE10]
    $rose(rst_n_q) |-> dq_oe_n ##1 dq_oe_n)
    else $error("bus driven after power-up");

  a_read_no_lanes : assert property ( // see [RULE13]
    (load && read_not_write) |=> st_q.s1.be == 4'h0)
    else $error("read carried byte enables");

  a_order_step : assert property ( // see [RULE14]
    st_q.s1.valid |-> st_q.s1.addr[1:0] ==
      (st_q.lin_n ? (st_q.burst_base ^ st_q.burst_cnt) : (st_q.burst_base + st_q.burst_cnt)))
    else $error("burst address out of order");

  c_load_read  : cover property ((load && read_not_write) ##3 !dq_oe_n);
  c_burst_wrap : cover property (advance ##1 advance ##1 advance ##1 advance);
  c_write_burst: cover property ((load && !read_not_write) ##1 advance);
  c_suspend    : cover property (!dq_oe_n ##1 !active ##1 !active);

endmodule : zsr_sram

// >>> verification/zsr_ctrl_model.sv
// Memory controller model facing the SRAM pins.
// Assumes the bench drives commands; this model owns the write data.
`timescale 1ns/10ps
module zsr_ctrl_model (
  input  wire logic                       clock,
  input  wire logic                       clock_gate_n,
  input  wire logic                       advance_or_load,
  input  wire logic                       read_not_write,
  input  wire logic                       select_a_n,
  input  wire logic                       select_b,
  input  wire logic                       select_c_n,
  output logic      [zsr_pkg::DATA_W-1:0] dq_in
);
  // ----------------------------------------------------------------------
  // Write data pipeline
  // ----------------------------------------------------------------------
  logic       on_q = 1'h0;
  logic       wr_q = 1'h0;
  logic [1:0] pipe_q = 2'h0;
  wire        sel = !select_a_n && select_b && !select_c_n;
  initial dq_in = 36'h5_a5a5_a5a5;
  // Never a stale value on the bus: inverted on every ungated edge outside write data cycles, held on gated edges
  always @(posedge clock) begin
    if (!clock_gate_n) begin
      if (!advance_or_load) begin
        on_q      <= sel;
        wr_q      <= !read_not_write;
        pipe_q[0] <= sel && !read_not_write;
      end else begin
        pipe_q[0] <= on_q && wr_q;
      end
      pipe_q[1] <= pipe_q[0];
      dq_in     <= pipe_q[1] ? ({dq_in[34:0], ~dq_in[35]} ^ 36'h9_6c3a_5e17) : ~dq_in;
    end
  end
endmodule : zsr_ctrl_model

// >>> verification/test_zsr_sram.sv
// Self-checking bench of the SRAM cycle logic against a queue-free model.
// Assumes zsr_pkg and the controller model are compiled first.
`timescale 1ns/10ps
module test_zsr_sram;
  logic                       clock = 1'h0, reset_n = 1'h0;
  logic [zsr_pkg::ADDR_W-1:0] addr = 18'h0, base = 18'h0;
  logic                       read_not_write = 1'h1, advance_or_load = 1'h0, clock_gate_n = 1'h0;
  logic                       select_a_n = 1'h1, select_b = 1'h0, select_c_n = 1'h1;
  logic [zsr_pkg::LANES-1:0]  byte_lane_write_n = 4'hf;
  logic                       linear_order_n = 1'h1;
  logic [zsr_pkg::DATA_W-1:0] dq_in, dq_out, exp_dq;
  logic                       dq_oe_n, write_busy, exp_rd = 1'h0, burst_ok = 1'h0, burst_wr = 1'h0;
  logic [1:0]                 lo;
  logic [31:0]                rnd = 32'h372d94b1;
  logic [35:0]                mem [16];
  logic [2:0]                 dsel [4] = '{3'h6, 3'h0, 3'h3, 3'h5};
  zsr_pkg::zsr_op_t           st [3];
  int                         cnt = 0, failures = 0, n_tests = 0;

  always #12.5 clock = ~clock;

  zsr_sram zsr_sram_i (.clock(clock), .reset_n(reset_n), .addr(addr), .read_not_write(read_not_write),
    .advance_or_load(advance_or_load), .select_a_n(select_a_n), .select_b(select_b),
    .select_c_n(select_c_n), .clock_gate_n(clock_gate_n), .byte_lane_write_n(byte_lane_write_n),
    .linear_order_n(linear_order_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .write_busy(write_busy));
  zsr_ctrl_model zsr_ctrl_model_i (.clock(clock), .clock_gate_n(clock_gate_n),
    .advance_or_load(advance_or_load), .read_not_write(read_not_write), .select_a_n(select_a_n),
    .select_b(select_b), .select_c_n(select_c_n), .dq_in(dq_in));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // Selects are {select_a_n, select_b, select_c_n}; 3'h2 selects
  task automatic drive(input logic adv, input logic rnw, input logic [2:0] sel, input logic gate_n,
                       input logic [17:0] a, input logic [3:0] be);
    @(posedge clock);
    advance_or_load   <= adv;
    read_not_write    <= rnw;
    {select_a_n, select_b, select_c_n} <= sel;
    clock_gate_n      <= gate_n;
    addr              <= a;
    byte_lane_write_n <= be;
  endtask : drive

  // ----------------------------------------------------------------------
  // Reference model, stepped on every edge that is not gated
  // ----------------------------------------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        st[i] = 24'h0;
      end
      exp_rd = 1'h0;
      burst_ok = 1'h0;
    end else if (!clock_gate_n) begin
      for (int i = 0; i < 4; i++) begin
        if (st[2].valid && st[2].write && !st[2].be[i]) begin
          mem[st[2].addr[3:0]][8*i +: 8] = dq_in[8*i +: 8];
          mem[st[2].addr[3:0]][32+i] = dq_in[32+i];
        end
      end
      st[2] = st[1];
      st[1] = st[0];
      st[0] = 24'h0;
      if (!advance_or_load) begin
        burst_ok = !select_a_n && select_b && !select_c_n;
        cnt = 0;
        base = addr;
        burst_wr = !read_not_write;
      end else begin
        cnt++;
      end
      if (burst_ok) begin
        lo = linear_order_n ? base[1:0] ^ 2'(cnt) : base[1:0] + 2'(cnt);
        st[0] = {1'h1, burst_wr, base[17:2], lo, byte_lane_write_n};
      end
      exp_rd = st[2].valid && !st[2].write;
      exp_dq = mem[st[2].addr[3:0]];
    end
  end

  always @(negedge clock) begin
    check(36'(dq_oe_n), 36'(!exp_rd));
    if (exp_rd) begin
      check(dq_out, exp_dq);
    end
    check(36'(write_busy), 36'h0);
  end

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    repeat (4) drive(1'h0, 1'h1, 3'h6, 1'h0, 18'h0, 4'hf);
    // Fill all words first so no read ever returns unwritten data
    for (int b = 0; b < 16; b += 4) begin
      drive(1'h0, 1'h0, 3'h2, 1'h0, 18'(b), 4'h0);
      repeat (3) drive(1'h1, 1'h1, 3'h2, 1'h0, 18'h3ffff, 4'h0);
    end
    for (int l = 0; l < 2; l++) begin
      drive(1'h0, 1'h1, 3'h6, 1'h0, 18'h0, 4'hf);
      linear_order_n <= l[0];
      repeat (4) drive(1'h1, 1'h0, 3'h2, 1'h0, 18'h0, 4'h0);
      // Every start offset, both directions, five advances to pass the wrap
      for (int s = 0; s < 8; s++) begin
        rnd = lfsr(rnd);
        drive(1'h0, s[0], 3'h2, 1'h0, 18'({s[2:1], s[2:1]}), rnd[3:0]);
        repeat (5) begin
          rnd = lfsr(rnd);
          drive(1'h1, rnd[4], 3'h2, 1'h0, 18'(rnd[21:4]), rnd[3:0]);
        end
      end
    end
    repeat (800) begin
      rnd = lfsr(rnd);
      drive(rnd[0], rnd[9], (rnd[6:4] == 3'h0) ? dsel[rnd[8:7]] : 3'h2, rnd[3:1] == 3'h0,
            18'(rnd[13:10]), rnd[17:14]);
    end
    repeat (4) drive(1'h0, 1'h1, 3'h6, 1'h0, 18'h0, 4'hf);
    results();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end
endmodule : test_zsr_sram
